/* bcm_pkg.sv */
// Constants and types for the decimal-correct and mask-load unit
package bcm_pkg;
    // ---------------------------------------------------------------
    // Opcode layout
    // ---------------------------------------------------------------
    localparam logic [7:0] OPC_GROUP = 8'h2c;
    localparam int OPC_HI_MSB = 15;
    localparam int OPC_HI_LSB = 8;
    localparam int SUB_MSB = 7;
    localparam int SUB_LSB = 6;
    localparam int TS_MSB = 5;
    localparam int TS_LSB = 4;
    localparam logic [1:0] SUB_DCA = 2'h0;
    localparam logic [1:0] SUB_DCS = 2'h1;
    localparam logic [1:0] SUB_LOAD_IMMEDIATE_IRQ_MASK_OP = 2'h2;
    localparam logic [1:0] TS_REG = 2'h0;
    localparam logic BYTE_HIGH = 1'b0;

    // ---------------------------------------------------------------
    // Status word bit positions (bit 15 is printed bit 0)
    // ---------------------------------------------------------------
    localparam int ST_LGT = 15;
    localparam int ST_AGT = 14;
    localparam int ST_EQ = 13;
    localparam int ST_CY = 12;
    localparam int ST_OV = 11;
    localparam int ST_PAR = 10;
    localparam int ST_DC = 8;
    localparam int MASK_MSB = 1;
    localparam int MASK_LSB = 0;
    localparam logic [15:0] STATUS_IMPL = 16'hfd03;
    localparam logic [15:0] STATUS_RST = 16'h0000;

    // ---------------------------------------------------------------
    // Digit arithmetic
    // ---------------------------------------------------------------
    localparam logic [3:0] DIGIT_ADJ_ADD = 4'h6;
    localparam logic [3:0] DIGIT_ADJ_SUB = 4'ha;
    localparam logic [3:0] DIGIT_LIMIT = 4'ha;
    localparam logic [3:0] HIGH_LIMIT_CARRY = 4'h9;

    // ---------------------------------------------------------------
    // Register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_RESULT = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;

    typedef enum logic [1:0] {
        BCM_IDLE = 2'b00,
        BCM_FETCH = 2'b01
    } bcm_state_e;

    typedef enum logic [1:0] {
        BCM_KIND_NONE = 2'b00,
        BCM_KIND_DCA = 2'b01,
        BCM_KIND_DCS = 2'b10,
        BCM_KIND_LOAD_IMMEDIATE_IRQ_MASK_OP = 2'b11
    } bcm_kind_e;
endpackage

/* bcm_digit_adjust.sv */
// Combinational BCD correction of one byte
`timescale 1ns/1ps
module bcm_digit_adjust
    import bcm_pkg::*;
(
    input wire logic [7:0] byteIn,
    input wire logic carryIn,
    input wire logic digitCarryIn,
    input wire logic isSub,
    output logic [7:0] byteOut,
    output logic carryOut,
    output logic digitCarryOut
);
    logic [3:0] hiDigit;
    logic [3:0] loDigit;
    logic loAdj;
    logic hiAdj;
    logic [4:0] loSum;

    assign hiDigit = byteIn[7:4];
    assign loDigit = byteIn[3:0];

    always_comb begin
        loAdj = 1'b0;
        hiAdj = 1'b0;
        loSum = {1'b0, loDigit};
        byteOut = byteIn;
        carryOut = carryIn;
        digitCarryOut = 1'b0;
        if (isSub) begin
            // Adding ten modulo 16 takes six off each digit whose carry is clear (CY for the high digit, DC for the low)
            if (!carryIn) begin
                byteOut[7:4] = hiDigit + DIGIT_ADJ_SUB;
            end
            if (!digitCarryIn) begin
                byteOut[3:0] = loDigit + DIGIT_ADJ_SUB;
            end
            carryOut = carryIn;
            digitCarryOut = !digitCarryIn;
        end else begin
            loAdj = digitCarryIn || (loDigit >= DIGIT_LIMIT);
            loSum = {1'b0, loDigit} + (loAdj ? {1'b0, DIGIT_ADJ_ADD} : 5'h00);
            hiAdj = carryIn || (hiDigit >= DIGIT_LIMIT)
                || ((loDigit >= DIGIT_LIMIT)
                && (hiDigit >= HIGH_LIMIT_CARRY));
            byteOut[3:0] = loSum[3:0];
            byteOut[7:4] = hiDigit + {3'h0, loSum[4]}
                + (hiAdj ? DIGIT_ADJ_ADD : 4'h0);
            carryOut = hiAdj;
            digitCarryOut = loSum[4];
        end
    end
endmodule

/* bcm_irq_gate.sv */
// Interrupt level acceptance against the two-bit mask
`timescale 1ns/1ps
module bcm_irq_gate
    import bcm_pkg::*;
(
    input wire logic irqPending,
    input wire logic [1:0] irqLevel,
    input wire logic [1:0] irqMask,
    output logic irqAccept
);
    // Levels 0 through the mask value pass
    assign irqAccept = irqPending && (irqLevel <= irqMask);
endmodule

/* bcm_unit.sv */
// Decimal-correct and interrupt-mask-load execution unit
`timescale 1ns/1ps
module bcm_unit
    import bcm_pkg::*;
#(
    parameter int REG_ADDR_W = 4,
    parameter int COUNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    output logic extOpClaim,
    output logic illegalOp,
    output logic busy,
    output logic opRdReq,
    output logic srcIsReg,
    input wire logic opRdValid,
    input wire logic [15:0] opRdData,
    input wire logic opByteLow,
    output logic wbValid,
    output logic [15:0] wbData,
    output logic wbByteLow,
    input wire logic stLoadEn,
    input wire logic [15:0] stLoadData,
    output logic [15:0] statusWord,
    input wire logic irqPending,
    input wire logic [1:0] irqLevel,
    output logic irqAccept,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData
);
    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    function automatic bcm_kind_e decodeKind(input logic [15:0] word);
        bcm_kind_e kind;
        kind = BCM_KIND_NONE;
        if (word[OPC_HI_MSB:OPC_HI_LSB] == OPC_GROUP) begin
            case (word[SUB_MSB:SUB_LSB])
                SUB_DCA: kind = BCM_KIND_DCA;
                SUB_DCS: kind = BCM_KIND_DCS;
                SUB_LOAD_IMMEDIATE_IRQ_MASK_OP: kind = BCM_KIND_LOAD_IMMEDIATE_IRQ_MASK_OP;
                default: kind = BCM_KIND_NONE;
            endcase
        end
        return kind;
    endfunction

    bcm_state_e state_q;
    bcm_state_e state_d;
    bcm_kind_e kindNow;
    logic [15:0] status_q;
    logic [15:0] status_d;
    logic isSub_q;
    logic isReg_q;
    logic takeInstr;
    logic execDecimal;
    logic doLiim;
    logic groupHit;
    logic [7:0] srcByte;
    logic [7:0] adjByte;
    logic adjCarry;
    logic adjDigitCarry;
    logic useLow;
    logic [7:0] result_q;
    logic [COUNT_W-1:0] execCount_q;
    logic regWrStatus;

    assign kindNow = decodeKind(instrWord);
    assign groupHit = instrWord[OPC_HI_MSB:OPC_HI_LSB] == OPC_GROUP;
    assign takeInstr = instrValid && (state_q == BCM_IDLE);
    assign extOpClaim = instrValid && groupHit;
    assign doLiim = takeInstr && (kindNow == BCM_KIND_LOAD_IMMEDIATE_IRQ_MASK_OP);
    assign execDecimal = (state_q == BCM_FETCH) && opRdValid;
    assign busy = state_q != BCM_IDLE;
    assign statusWord = status_q;
    assign regWrStatus = regWrStb && (regAddr == REG_STATUS[REG_ADDR_W-1:0]);

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            BCM_IDLE: begin
                if (takeInstr && ((kindNow == BCM_KIND_DCA)
                    || (kindNow == BCM_KIND_DCS))) begin
                    state_d = BCM_FETCH;
                end
            end
            BCM_FETCH: begin
                if (opRdValid) begin
                    state_d = BCM_IDLE;
                end
            end
            default: state_d = BCM_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= BCM_IDLE;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // Operand request and source kind captured at issue
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            opRdReq <= 1'b0;
            srcIsReg <= 1'b0;
            isSub_q <= 1'b0;
            isReg_q <= 1'b0;
            illegalOp <= 1'b0;
        end else if (clkEn) begin
            opRdReq <= (state_q == BCM_IDLE) && (state_d == BCM_FETCH);
            illegalOp <= takeInstr && groupHit
                && (kindNow == BCM_KIND_NONE);
            if (takeInstr) begin
                isSub_q <= kindNow == BCM_KIND_DCS;
                isReg_q <= instrWord[TS_MSB:TS_LSB] == TS_REG;
                srcIsReg <= instrWord[TS_MSB:TS_LSB] == TS_REG;
            end
        end
    end

    // ---------------------------------------------------------------
    // Datapath
    // ---------------------------------------------------------------
    assign useLow = !isReg_q && opByteLow;
    assign srcByte = useLow ? opRdData[7:0] : opRdData[15:8];

    bcm_digit_adjust u_adjust (
        .byteIn(srcByte),
        .carryIn(status_q[ST_CY]),
        .digitCarryIn(status_q[ST_DC]),
        .isSub(isSub_q),
        .byteOut(adjByte),
        .carryOut(adjCarry),
        .digitCarryOut(adjDigitCarry)
    );

    // Write-back merges the corrected byte into the fetched word
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wbValid <= 1'b0;
            wbData <= 16'h0000;
            wbByteLow <= BYTE_HIGH;
            result_q <= 8'h00;
        end else if (clkEn) begin
            wbValid <= execDecimal;
            if (execDecimal) begin
                wbByteLow <= useLow;
                result_q <= adjByte;
                wbData <= useLow ? {opRdData[15:8], adjByte}
                    : {adjByte, opRdData[7:0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // Status word
    // ---------------------------------------------------------------
    always_comb begin
        status_d = status_q;
        if (execDecimal) begin
            status_d[ST_LGT] = adjByte != 8'h00;
            status_d[ST_AGT] = !adjByte[7] && (adjByte != 8'h00);
            status_d[ST_EQ] = adjByte == 8'h00;
            status_d[ST_CY] = adjCarry;
            status_d[ST_PAR] = ^adjByte;
            status_d[ST_DC] = adjDigitCarry;
        end else if (doLiim) begin
            status_d[MASK_MSB:MASK_LSB] = instrWord[1:0];
        end else if (stLoadEn) begin
            status_d = stLoadData;
        end else if (regWrStatus) begin
            status_d = regWrData[15:0];
        end
        // Unused bits and the missing extended-operation bit stay zero
        status_d = status_d & STATUS_IMPL;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_q <= STATUS_RST;
        end else if (clkEn) begin
            status_q <= status_d;
        end
    end

    bcm_irq_gate u_irq (
        .irqPending(irqPending),
        .irqLevel(irqLevel),
        .irqMask(status_q[MASK_MSB:MASK_LSB]),
        .irqAccept(irqAccept)
    );

    // ---------------------------------------------------------------
    // Register port
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            execCount_q <= '0;
        end else if (clkEn) begin
            if (regWrStb && (regAddr == REG_COUNT[REG_ADDR_W-1:0])) begin
                execCount_q <= '0;
            end else if (execDecimal || doLiim) begin
                execCount_q <= execCount_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            regRdData <= 32'h0000_0000;
        end else if (clkEn) begin
            regRdData <= 32'h0000_0000;
            if (regRdStb) begin
                case (regAddr)
                    REG_STATUS[REG_ADDR_W-1:0]:
                        regRdData <= {16'h0000, status_q};
                    REG_RESULT[REG_ADDR_W-1:0]:
                        regRdData <= {24'h00_0000, result_q};
                    REG_COUNT[REG_ADDR_W-1:0]:
                        regRdData <= 32'(execCount_q);
                    default: regRdData <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cbDef @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst || !clkEn);

    AST_LOAD_IMMEDIATE_IRQ_MASK_OP_MASK: assert property (
        doLiim && !stLoadEn |=> status_q[1:0] == $past(instrWord[1:0]))
        else $error("Mask load did not set the mask");

    AST_LOAD_IMMEDIATE_IRQ_MASK_OP_KEEP: assert property (
        doLiim |=> status_q[15:2] == $past(status_q[15:2]))
        else $error("Mask load disturbed other status bits");

    AST_IRQ_GATE: assert property (
        irqPending && (irqLevel > status_q[1:0]) |-> !irqAccept)
        else $error("Interrupt above mask level accepted");

    AST_ISSUE_FETCH: assert property (
        takeInstr && (decodeKind(instrWord) == BCM_KIND_DCA)
        |=> opRdReq && busy ##1 !opRdReq)
        else $error("Add correction did not fetch its operand");

    AST_SUB_ISSUE: assert property (
        takeInstr && (decodeKind(instrWord) == BCM_KIND_DCS)
        |=> isSub_q && opRdReq)
        else $error("Subtract correction not issued");

    AST_WB_ONE_CYCLE: assert property (
        execDecimal |=> wbValid && !busy ##1 !wbValid)
        else $error("Write-back not a single pulse after operand");

    AST_EQ_FLAG: assert property (
        wbValid |-> status_q[ST_EQ] == (result_q == 8'h00)
            && status_q[ST_LGT] == (result_q != 8'h00))
        else $error("Compare flags disagree with result");

    AST_PARITY: assert property (
        wbValid |-> status_q[ST_PAR] == ^result_q)
        else $error("Parity flag wrong");

    AST_KEEP_OV_MASK: assert property (
        execDecimal |=> status_q[ST_OV] == $past(status_q[ST_OV])
            && status_q[1:0] == $past(status_q[1:0]))
        else $error("Decimal op changed overflow or mask");

    AST_SUB_CARRY: assert property (
        execDecimal && isSub_q
        |=> status_q[ST_CY] == $past(status_q[ST_CY]))
        else $error("Subtract correction changed carry");

    AST_CLAIM: assert property (
        extOpClaim == (instrValid
            && (instrWord[OPC_HI_MSB:OPC_HI_LSB] == OPC_GROUP)))
        else $error("Extended opcode claim wrong");

    AST_AGT_FLAG: assert property (
        wbValid |-> status_q[ST_AGT]
            == (!result_q[7] && (result_q != 8'h00)))
        else $error("Arithmetic greater flag wrong");

    AST_ADD_CARRY: assert property (
        execDecimal && !isSub_q && status_q[ST_CY] |=> status_q[ST_CY])
        else $error("Add correction dropped carry");

    AST_SUB_DIGIT: assert property (
        execDecimal && isSub_q
        |=> status_q[ST_DC] != $past(status_q[ST_DC]))
        else $error("Subtract correction digit carry wrong");

    AST_UNUSED_ZERO: assert property (
        (status_q & ~STATUS_IMPL) == 16'h0000)
        else $error("Unimplemented status bit set");

    AST_REG_HIGH: assert property (
        execDecimal && isReg_q |=> wbValid && (wbByteLow == BYTE_HIGH))
        else $error("Register operand not corrected in high byte");

    AST_IRQ_ACCEPT: assert property (
        irqPending && (irqLevel <= status_q[1:0]) |-> irqAccept)
        else $error("Interrupt within mask level refused");

    COV_DCA: cover property (execDecimal && !isSub_q);
    COV_DCS: cover property (execDecimal && isSub_q);
    COV_LOAD_IMMEDIATE_IRQ_MASK_OP: cover property (doLiim);
    COV_IRQ: cover property (irqAccept && status_q[1:0] == 2'h2);
    COV_ILLEGAL: cover property (illegalOp);
endmodule

/* tb_bcm_unit.sv */
// Self-checking bench for the decimal-correct and mask-load unit
`timescale 1ns/1ps
module tb_bcm_unit;
    import bcm_pkg::*;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic instrValid = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic extOpClaim, illegalOp, busy, opRdReq, srcIsReg;
    logic opRdValid = 1'b0;
    logic [15:0] opRdData = 16'h0000;
    logic opByteLow = 1'b0;
    logic wbValid, wbByteLow, irqAccept;
    logic [15:0] wbData, statusWord;
    logic stLoadEn = 1'b0;
    logic [15:0] stLoadData = 16'h0000;
    logic irqPending = 1'b0;
    logic [1:0] irqLevel = 2'h0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [31:0] regRdData, rd;
    int errCount = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 64;
    logic [31:0] r;
    logic [15:0] st;
    logic [7:0] lastByte = 8'h00;

    bcm_unit DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn),
        .instrValid(instrValid), .instrWord(instrWord),
        .extOpClaim(extOpClaim), .illegalOp(illegalOp), .busy(busy),
        .opRdReq(opRdReq), .srcIsReg(srcIsReg), .opRdValid(opRdValid),
        .opRdData(opRdData), .opByteLow(opByteLow), .wbValid(wbValid),
        .wbData(wbData), .wbByteLow(wbByteLow), .stLoadEn(stLoadEn),
        .stLoadData(stLoadData), .statusWord(statusWord),
        .irqPending(irqPending), .irqLevel(irqLevel),
        .irqAccept(irqAccept), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));

    // ---------------------------------------------------------------
    // Clock, timeout, checks
    // ---------------------------------------------------------------
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            errCount++;
            endSim();
        end
    end

    task automatic endSim();
        $display("comparisons %0d mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errCount++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        chkVal({31'h0, got}, {31'h0, exp});
    endtask

    // ---------------------------------------------------------------
    // Expected result: {byte, status}
    // ---------------------------------------------------------------
    function automatic logic [23:0] model(input logic [15:0] s,
        input logic [7:0] b, input logic sub);
        logic c, dc, la, ha, co, dco;
        logic [7:0] v;
        c = s[ST_CY];
        dc = s[ST_DC];
        if (!sub) begin
            la = dc || b[3:0] >= 4'ha;
            ha = c || b[7:4] >= 4'ha || (b[3:0] >= 4'ha && b[7:4] >= 4'h9);
            v = b + (la ? 8'h06 : 8'h00) + (ha ? 8'h60 : 8'h00);
            co = ha;
            dco = ({1'b0, b[3:0]} + (la ? 5'h06 : 5'h00)) > 5'h0f;
        end else begin
            v = {b[7:4] + (c ? 4'h0 : 4'ha), b[3:0] + (dc ? 4'h0 : 4'ha)};
            co = c;
            dco = !dc;
        end
        s[ST_LGT] = v != 8'h00;
        s[ST_AGT] = !v[7] && v != 8'h00;
        s[ST_EQ] = v == 8'h00;
        s[ST_CY] = co;
        s[ST_PAR] = ^v;
        s[ST_DC] = dco;
        return {v, s};
    endfunction

    // ---------------------------------------------------------------
    // Drivers
    // ---------------------------------------------------------------
    task automatic busWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
    endtask

    task automatic busRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic stLoad(input logic [15:0] v);
        @(posedge clk_sys);
        stLoadEn <= 1'b1;
        stLoadData <= v;
        @(posedge clk_sys);
        stLoadEn <= 1'b0;
        #1 chkVal(statusWord, v & STATUS_IMPL);
    endtask

    task automatic runMask(input logic [1:0] m);
        logic [15:0] e;
        e = (statusWord & 16'hfffc) | {14'h0, m};
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrWord <= {OPC_GROUP, SUB_LOAD_IMMEDIATE_IRQ_MASK_OP, 4'h0, m};
        #1 chkBit(extOpClaim, 1'b1);
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1 chkVal(statusWord, e);
    endtask

    task automatic runDec(input logic sub, input logic [1:0] mode,
        input logic [3:0] rg, input logic [15:0] d, input logic low);
        logic [23:0] m;
        logic useLow;
        logic [15:0] e;
        useLow = (mode != TS_REG) && low;
        m = model(statusWord, useLow ? d[7:0] : d[15:8], sub);
        e = useLow ? {d[15:8], m[23:16]} : {m[23:16], d[7:0]};
        lastByte = m[23:16];
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrWord <= {OPC_GROUP, sub ? SUB_DCS : SUB_DCA, mode, rg};
        opByteLow <= low;
        opRdData <= d;
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1 chkBit(opRdReq, 1'b1);
        chkBit(srcIsReg, mode == TS_REG);
        @(posedge clk_sys);
        opRdValid <= 1'b1;
        @(posedge clk_sys);
        opRdValid <= 1'b0;
        #1 chkBit(wbValid, 1'b1);
        chkVal(wbData, e);
        chkBit(wbByteLow, useLow);
        chkVal(statusWord, m[15:0]);
        chkBit(busy, 1'b0);
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    logic [15:0] cData [4] = '{16'h0d00, 16'h0f00, 16'h9a00, 16'h0099};
    logic [15:0] cSt [4] = '{16'h0000, 16'h1000, 16'h0000, 16'h1100};
    logic cSub [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 chkVal(statusWord, STATUS_RST);
        chkBit(busy, 1'b0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            r = $random(seed);
            stLoad(r[15:0]);
            runMask(m[1:0]);
            for (int l = 0; l < 4; l++) begin
                @(posedge clk_sys);
                irqPending <= 1'b1;
                irqLevel <= l[1:0];
                #1 chkBit(irqAccept, l <= m);
            end
            @(posedge clk_sys);
            irqPending <= 1'b0;
            #1 chkBit(irqAccept, 1'b0);
        end
        $display("test mask load done");
        busWr(REG_COUNT, 32'h0);
        for (int i = 0; i < 4; i++) begin
            stLoad(cSt[i]);
            runDec(cSub[i], TS_REG, 4'h1, cData[i], 1'b0);
        end
        for (int i = 0; i < 36; i++) begin
            r = $random(seed);
            stLoad(r[15:0]);
            r = $random(seed);
            runDec(r[20], r[19:18], r[3:0], r[15:0], r[21]);
        end
        busRd(REG_COUNT, rd);
        chkVal(rd & 32'h0000ffff, 32'd40);
        busRd(REG_RESULT, rd);
        chkVal(rd, {24'h0, lastByte});
        $display("test decimal done");
        st = statusWord;
        @(posedge clk_sys);
        instrValid <= 1'b1;
        instrWord <= 16'h2cc5;
        #1 chkBit(extOpClaim, 1'b1);
        @(posedge clk_sys);
        instrWord <= 16'h2d00;
        #1 chkBit(illegalOp, 1'b1);
        chkBit(extOpClaim, 1'b0);
        @(posedge clk_sys);
        instrValid <= 1'b0;
        #1 chkVal(statusWord, st);
        chkBit(busy, 1'b0);
        chkBit(illegalOp, 1'b0);
        $display("test claim done");
        @(posedge clk_sys);
        clkEn <= 1'b0;
        stLoadEn <= 1'b1;
        stLoadData <= ~st;
        @(posedge clk_sys);
        clkEn <= 1'b1;
        stLoadEn <= 1'b0;
        #1 chkVal(statusWord, st);
        $display("test clock enable done");
        r = $random(seed);
        busWr(REG_STATUS, r);
        busRd(REG_STATUS, rd);
        chkVal(rd, {16'h0, r[15:0] & STATUS_IMPL});
        busRd(4'hc, rd);
        chkVal(rd, 32'h0);
        $display("test register bus done");
        endSim();
    end
endmodule
